// ==== tb/tmps_tb_top.sv ====
// testbench: apb register checks, pwm steering and standby clearing
`timescale 1ns/1ps
module tmps_tb_top
  import tmps_pkg::*;
;
  // apb side
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  // standby requests
  logic hw_standby_pin;
  logic sw_standby;
  // timer pins and config outputs
  logic [CH_NUM-1:0] pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe, pd_o, pd_oe;
  logic [CH_NUM-1:0] pwm_mode;
  logic [3:0] duty_pol;
  logic [3:0] comp_sel;
  // bookkeeping
  int errors;
  int n_tests;
  int cycles;
  logic [DATA_W-1:0] rd;
  logic err;

  tmps_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_standby_pin(hw_standby_pin), .sw_standby(sw_standby),
    .pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o), .pin_b_oe(pb_oe),
    .pin_c_o(pc_o), .pin_c_oe(pc_oe), .pin_d_o(pd_o), .pin_d_oe(pd_oe),
    .pwm_mode(pwm_mode), .out_duty_polarity(duty_pol), .counter_comp_select(comp_sel));

  // 250 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // hang guard: whole run is well under this
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  // compare one value, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready sampled at the rising edge, before that edge's own updates land
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    // answer taken at the same edge that completes the transfer
    rd = prdata;
    err = pslverr;
    // one wait state: answer at the second access edge
    chk(n, 2, "pready wait");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read and compare in one call
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rchk

  // count pin highs of one channel over 16 cycles (two full periods of 8)
  task automatic cnt16(input int ch, output int na, output int nb, output int nc);
    na = 0;
    nb = 0;
    nc = 0;
    repeat (16)
    begin
      @(negedge pclk);
      na += pa_o[ch];
      nb += pb_o[ch];
      nc += pc_o[ch];
    end
  endtask : cnt16

  // single end-of-run point
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    int na, nb, nc;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_standby_pin = 1'b0;
    sw_standby = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;

    // reset values of both registers
    rchk(OFF_MODE, 32'h0, "mode reset");
    rchk(OFF_PWM6, 32'h0, "pwm6 reset");
    $display("test reset done");

    // reserved mode bits dropped, selects stored
    apb(1'b1, OFF_MODE, 32'hff);
    rchk(OFF_MODE, 32'h07, "mode reserved");
    chk(pwm_mode, 3'b111, "pwm selects");
    apb(1'b1, OFF_MODE, 32'hfa);
    rchk(OFF_MODE, 32'h02, "mode write fa");
    $display("test mode bits done");

    // pwm6 fields, both checkerboards
    apb(1'b1, OFF_PWM6, 32'ha5);
    rchk(OFF_PWM6, 32'ha5, "pwm6 a5");
    chk(duty_pol, 4'ha, "duty pol a5");
    chk(comp_sel, 4'h5, "comp sel a5");
    apb(1'b1, OFF_PWM6, 32'h5a);
    // the write lands at the edge the task returns on; look once it has settled
    @(negedge pclk);
    chk(duty_pol, 4'h5, "duty pol 5a");
    chk(comp_sel, 4'ha, "comp sel 5a");
    $display("test pwm6 done");

    // compare mode: pins follow io control; ch3 all high, ch4 pin a low
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, 8'h40, 32'h33);
    apb(1'b1, 8'h44, 32'h33);
    apb(1'b1, 8'h48, 32'h11);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h14, 32'h5);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h1c, 32'h7);
    repeat (3) @(negedge pclk);
    chk({pa_oe[0], pa_o[0], pd_oe[0], pd_o[0]}, 4'hf, "ch3 compare pins");
    chk({pa_oe[1], pa_o[1]}, 2'b10, "ch4 compare pin a");

    // ch3 to pwm: period gr d + 1 = 8, duties 2, 5, 0
    apb(1'b1, OFF_MODE, 32'h01);
    repeat (20) @(negedge pclk);
    chk({pa_oe[0], pb_oe[0], pc_oe[0]}, 3'b111, "ch3 pwm enables");
    chk(pd_oe[0], 1'b0, "ch3 pin d released");
    cnt16(0, na, nb, nc);
    chk(na, 4, "ch3 a highs");
    chk(nb, 10, "ch3 b highs");
    chk(nc, 0, "ch3 c highs");
    chk({pa_oe[1], pa_o[1]}, 2'b10, "ch4 untouched");
    $display("test pwm steering done");

    // general registers writable in pwm mode
    apb(1'b1, OFF_MODE, 32'h07);
    apb(1'b1, 8'h3c, 32'h0000beef);
    rchk(8'h3c, 32'h0000beef, "ch5 period write");
    apb(1'b1, 8'h10, 32'h4);
    repeat (20) @(negedge pclk);
    cnt16(0, na, nb, nc);
    chk(na, 8, "ch3 new duty");
    $display("test gr write done");

    // unmapped address refused
    apb(1'b1, 8'h80, 32'hffff);
    chk(err, 1'b1, "unmapped write err");
    rchk(8'h80, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped read err");
    $display("test unmapped done");

    // software standby clears both registers
    apb(1'b1, OFF_PWM6, 32'h3c);
    @(posedge pclk);
    sw_standby <= 1'b1;
    repeat (3) @(posedge pclk);
    sw_standby <= 1'b0;
    rchk(OFF_MODE, 32'h0, "mode sw standby");
    rchk(OFF_PWM6, 32'h0, "pwm6 sw standby");
    chk(pwm_mode, 3'b000, "pwm off sw standby");

    // hardware standby through its synchroniser
    apb(1'b1, OFF_MODE, 32'h05);
    apb(1'b1, OFF_PWM6, 32'hc3);
    @(posedge pclk);
    hw_standby_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    hw_standby_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk(OFF_MODE, 32'h0, "mode hw standby");
    rchk(OFF_PWM6, 32'h0, "pwm6 hw standby");
    rchk(8'h10, 32'h4, "gr kept over standby");
    $display("test standby done");

    report_and_stop();
  end

endmodule : tmps_tb_top

// ==== verilog/tmps_pkg.sv ====
// package: register map, field layout and reset values of the timer mode select block
//
// Overview of operation
// - mode register bits 7..3 always read zero
// - both registers clear on reset and standby
// - bits 0..2 pick pwm for channels 3..5
// - pwm channel drives pins a, b, c
// - gr d is period, gr a..c duty
// - pwm channel ignores its io control registers
// - general registers stay writable in pwm mode
// - bits 7..4 give outputs d..a duty polarity
// - bits 3..0 give counters d..a complementary mode
package tmps_pkg;

  // bus and register geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int GR_W = 16;
  localparam int CH_NUM = 3;
  localparam int GR_NUM = 12;
  localparam int IOC_NUM = 6;

  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_PWM6 = 8'h04;
  localparam logic [7:0] OFF_GR_BASE = 8'h10;
  localparam logic [7:0] OFF_GR_LAST = 8'h3c;
  localparam logic [7:0] OFF_IOC_BASE = 8'h40;
  localparam logic [7:0] OFF_IOC_LAST = 8'h54;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PWM6_RST = 8'h00;
  localparam logic [15:0] GR_RST = 16'h0000;
  localparam logic [7:0] IOC_RST = 8'h00;

  // mode register: only the three pwm selects are stored
  localparam logic [7:0] MODE_WMASK = 8'h07;
  localparam int PWM_SEL_LSB = 0;

  // pwm6 register fields
  localparam int DUTY_POL_LSB = 4;
  localparam int COMP_SEL_LSB = 0;

  // io control fields: low nibble first pin, high nibble second pin
  localparam int IOC_EN_BIT = 0;
  localparam int IOC_LVL_BIT = 1;
  localparam int IOC_HI_LSB = 4;

  // general register slots within a channel
  localparam int GR_A = 0;
  localparam int GR_B = 1;
  localparam int GR_C = 2;
  localparam int GR_D = 3;

endpackage : tmps_pkg

// ==== verilog/tmps_pwm_chan.sv ====
// one channel of pwm waveform generation: shared period, three duties
`timescale 1ns/1ps
module tmps_pwm_chan
  import tmps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic en,
  input wire logic [GR_W-1:0] period,
  input wire logic [GR_W-1:0] duty_a,
  input wire logic [GR_W-1:0] duty_b,
  input wire logic [GR_W-1:0] duty_c,
  // waveforms
  output logic out_a,
  output logic out_b,
  output logic out_c
);

  logic [GR_W-1:0] cnt_r; // period counter

  // counter wraps at the period value, held at zero when off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (!en)
      cnt_r <= '0;
    else if (cnt_r >= period)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 16'h0001;
  end

  // outputs high while the count is below each duty value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
    end
    else
    begin
      out_a <= en && (cnt_r < duty_a);
      out_b <= en && (cnt_r < duty_b);
      out_c <= en && (cnt_r < duty_c);
    end
  end

  // the period register bounds the cycle
  per_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    en && $stable(en) && cnt_r == period |=> cnt_r == 16'h0000 || !$past(en))
    else $error("counter did not wrap at period");

endmodule : tmps_pwm_chan

// ==== verilog/tmps_top.sv ====
// top: apb register file and mode steering for timer channels 3 to 5
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module tmps_top
  import tmps_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  // apb answer
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // standby requests
  input wire logic hw_standby_pin,
  input wire logic sw_standby,
  // timer pins of channels 3..5, index 0 is channel 3
  output logic [CH_NUM-1:0] pin_a_o,
  output logic [CH_NUM-1:0] pin_a_oe,
  output logic [CH_NUM-1:0] pin_b_o,
  output logic [CH_NUM-1:0] pin_b_oe,
  output logic [CH_NUM-1:0] pin_c_o,
  output logic [CH_NUM-1:0] pin_c_oe,
  output logic [CH_NUM-1:0] pin_d_o,
  output logic [CH_NUM-1:0] pin_d_oe,
  // mode flags toward the channel logic
  output logic [CH_NUM-1:0] pwm_mode,
  // channel 6 configuration, index 0 is output a
  output logic [3:0] out_duty_polarity,
  output logic [3:0] counter_comp_select
);

  // stored registers
  logic [7:0] mode_r; // channel_mode_select
  logic [7:0] pwm6_r; // pwm6_output_mode
  logic [GR_W-1:0] gr_r [GR_NUM]; // general registers a..d per channel
  logic [7:0] ioc_r [IOC_NUM]; // two io control registers per channel

  // bus answer flops
  logic pready_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r;

  // standby synchroniser
  logic hsb_s1_r;
  logic hsb_s2_r;
  logic hsb_s3_r;
  logic hw_sb_r;

  // decode
  logic acc_done; // access completes at this edge
  logic addr_err; // unmapped or misaligned
  logic wr_ev; // a write takes effect
  logic std_clr; // standby clears mode registers
  logic [DATA_W-1:0] rd_nxt;

  // pin drive, next values
  logic [CH_NUM-1:0] a_nxt;
  logic [CH_NUM-1:0] a_oe_nxt;
  logic [CH_NUM-1:0] b_nxt;
  logic [CH_NUM-1:0] b_oe_nxt;
  logic [CH_NUM-1:0] c_nxt;
  logic [CH_NUM-1:0] c_oe_nxt;
  logic [CH_NUM-1:0] d_nxt;
  logic [CH_NUM-1:0] d_oe_nxt;

  // pwm waveforms
  logic [CH_NUM-1:0] pwm_a;
  logic [CH_NUM-1:0] pwm_b;
  logic [CH_NUM-1:0] pwm_c;

  // address falls in the general register window
  function automatic logic is_gr(input logic [ADDR_W-1:0] a);
    return a >= OFF_GR_BASE && a <= OFF_GR_LAST && a[1:0] == 2'b00;
  endfunction : is_gr

  // address falls in the io control window
  function automatic logic is_ioc(input logic [ADDR_W-1:0] a);
    return a >= OFF_IOC_BASE && a <= OFF_IOC_LAST && a[1:0] == 2'b00;
  endfunction : is_ioc

  // word index within the general register window
  function automatic logic [3:0] gr_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_GR_BASE;
    return d[5:2];
  endfunction : gr_idx

  // word index within the io control window
  function automatic logic [2:0] ioc_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_IOC_BASE;
    return d[4:2];
  endfunction : ioc_idx

  // hardware standby pin: three flops, accept once two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hsb_s1_r <= 1'b0;
      hsb_s2_r <= 1'b0;
      hsb_s3_r <= 1'b0;
      hw_sb_r <= 1'b0;
    end
    else
    begin
      hsb_s1_r <= hw_standby_pin;
      hsb_s2_r <= hsb_s1_r;
      hsb_s3_r <= hsb_s2_r;
      if (hsb_s2_r == hsb_s3_r)
        hw_sb_r <= hsb_s3_r;
    end
  end

  // either standby mode holds the mode registers cleared
  assign std_clr = hw_sb_r || sw_standby;

  // request decode
  assign addr_err = !(paddr == OFF_MODE || paddr == OFF_PWM6 ||
                      is_gr(paddr) || is_ioc(paddr));
  assign acc_done = psel && penable && pready_r;
  assign wr_ev = acc_done && pwrite && !addr_err;

  // one wait state: answer flops load in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_r <= 1'b0;
    else
      pready_r <= psel && penable && !pready_r;
  end

  // read data mux, reserved and unmapped bits read zero
  always_comb
  begin
    rd_nxt = '0;
    if (paddr == OFF_MODE)
      rd_nxt[7:0] = mode_r & MODE_WMASK;
    else if (paddr == OFF_PWM6)
      rd_nxt[7:0] = pwm6_r;
    else if (is_gr(paddr))
      rd_nxt[GR_W-1:0] = gr_r[gr_idx(paddr)];
    else if (is_ioc(paddr))
      rd_nxt[7:0] = ioc_r[ioc_idx(paddr)];
  end

  // read data and error captured at the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
    else if (psel && penable && !pready_r)
    begin
      prdata_r <= pwrite ? '0 : rd_nxt;
      pslverr_r <= addr_err;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && pready_r;

  // mode register: standby clear beats a write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= MODE_RST;
    else if (std_clr)
      mode_r <= MODE_RST;
    else if (wr_ev && paddr == OFF_MODE)
      mode_r <= pwdata[7:0] & MODE_WMASK;
  end

  // pwm6 output mode register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm6_r <= PWM6_RST;
    else if (std_clr)
      pwm6_r <= PWM6_RST;
    else if (wr_ev && paddr == OFF_PWM6)
      pwm6_r <= pwdata[7:0];
  end

  // general registers: writable in every mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < GR_NUM; i++)
        gr_r[i] <= GR_RST;
    end
    else if (wr_ev && is_gr(paddr))
      gr_r[gr_idx(paddr)] <= pwdata[GR_W-1:0];
  end

  // io control registers, still stored while pwm ignores them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < IOC_NUM; i++)
        ioc_r[i] <= IOC_RST;
    end
    else if (wr_ev && is_ioc(paddr))
      ioc_r[ioc_idx(paddr)] <= pwdata[7:0];
  end

  // mode flags, field slices of the stored registers
  assign pwm_mode = mode_r[PWM_SEL_LSB +: CH_NUM];
  assign out_duty_polarity = pwm6_r[DUTY_POL_LSB +: 4];
  assign counter_comp_select = pwm6_r[COMP_SEL_LSB +: 4];

  // one pwm generator per channel, period from d, duty from a..c
  for (genvar c = 0; c < CH_NUM; c++)
  begin : g_pwm
    tmps_pwm_chan u_pwm (
      .pclk(pclk),
      .presetn(presetn),
      .en(pwm_mode[c]),
      .period(gr_r[4*c+GR_D]),
      .duty_a(gr_r[4*c+GR_A]),
      .duty_b(gr_r[4*c+GR_B]),
      .duty_c(gr_r[4*c+GR_C]),
      .out_a(pwm_a[c]),
      .out_b(pwm_b[c]),
      .out_c(pwm_c[c])
    );
  end

  // pin steering: pwm overrides io control, which is then ignored
  always_comb
  begin
    for (int c = 0; c < CH_NUM; c++)
    begin
      if (pwm_mode[c])
      begin
        // pwm drives a..c; d is released so software cannot clash
        a_nxt[c] = pwm_a[c];
        a_oe_nxt[c] = 1'b1;
        b_nxt[c] = pwm_b[c];
        b_oe_nxt[c] = 1'b1;
        c_nxt[c] = pwm_c[c];
        c_oe_nxt[c] = 1'b1;
        d_nxt[c] = 1'b0;
        d_oe_nxt[c] = 1'b0;
      end
      else
      begin
        // compare mode: static levels from io control
        a_nxt[c] = ioc_r[2*c][IOC_LVL_BIT];
        a_oe_nxt[c] = ioc_r[2*c][IOC_EN_BIT];
        b_nxt[c] = ioc_r[2*c][IOC_HI_LSB+IOC_LVL_BIT];
        b_oe_nxt[c] = ioc_r[2*c][IOC_HI_LSB+IOC_EN_BIT];
        c_nxt[c] = ioc_r[2*c+1][IOC_LVL_BIT];
        c_oe_nxt[c] = ioc_r[2*c+1][IOC_EN_BIT];
        d_nxt[c] = ioc_r[2*c+1][IOC_HI_LSB+IOC_LVL_BIT];
        d_oe_nxt[c] = ioc_r[2*c+1][IOC_HI_LSB+IOC_EN_BIT];
      end
    end
  end

  // pins registered so no decode glitch reaches them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_a_o <= '0;
      pin_a_oe <= '0;
      pin_b_o <= '0;
      pin_b_oe <= '0;
      pin_c_o <= '0;
      pin_c_oe <= '0;
      pin_d_o <= '0;
      pin_d_oe <= '0;
    end
    else
    begin
      pin_a_o <= a_nxt;
      pin_a_oe <= a_oe_nxt;
      pin_b_o <= b_nxt;
      pin_b_oe <= b_oe_nxt;
      pin_c_o <= c_nxt;
      pin_c_oe <= c_oe_nxt;
      pin_d_o <= d_nxt;
      pin_d_oe <= d_oe_nxt;
    end
  end

  // reserved mode bits never read back as one
  rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !pwrite && paddr == OFF_MODE |-> prdata[7:3] == 5'h00)
    else $error("reserved mode bits read nonzero");

  // standby clears both registers on the next edge
  stdby_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    std_clr |=> mode_r == 8'h00 && pwm6_r == 8'h00)
    else $error("standby did not clear mode registers");

  // a mode write keeps only the select bits
  mode_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ev && paddr == OFF_MODE && !std_clr |=> mode_r == ($past(pwdata[7:0]) & 8'h07))
    else $error("mode write stored wrong value");

  // select bit one puts the channel in pwm
  sel_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ev && paddr == OFF_MODE && !std_clr |=> pwm_mode == $past(pwdata[2:0]))
    else $error("pwm select mapping wrong");

  // pwm channel drives its a pin from the generator
  pwm_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode[0] |=> pin_a_oe[0] && pin_a_o[0] == $past(pwm_a[0]))
    else $error("pwm channel pin a not driven");

  // io control has no effect on a pwm channel
  ioc_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode[1] && $stable(pwm_mode[1]) |=> pin_b_oe[1] && pin_c_oe[1])
    else $error("io control leaked into pwm channel");

  // general register accepts writes even in pwm mode
  gr_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ev && paddr == OFF_GR_BASE |=> gr_r[0] == $past(pwdata[15:0]))
    else $error("general register write lost");

  // pin d released while in pwm
  pin_d_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode[2] |=> !pin_d_oe[2])
    else $error("pin d driven in pwm mode");

  // pwm6 fields land on their outputs
  pol_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ev && paddr == OFF_PWM6 && !std_clr |=> out_duty_polarity == $past(pwdata[7:4]))
    else $error("duty polarity mapping wrong");

  comp_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ev && paddr == OFF_PWM6 && !std_clr |=> counter_comp_select == $past(pwdata[3:0]))
    else $error("counter mode mapping wrong");

  // exactly one wait state in every access
  one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");

endmodule : tmps_top
